/* hdl/uart_fmt_defs.svh */
// Register map, field positions and reset values for the format block.
// Included by the design files and the bench; definitions only.
`ifndef UART_FMT_DEFS_SVH
`define UART_FMT_DEFS_SVH
`define ADDR_DATA0        3'h0
`define ADDR_DATA1        3'h1
`define ADDR_FIFO_CTRL    3'h2
`define ADDR_LINE_CTRL    3'h3
`define ADDR_MODEM_CTRL   3'h4
`define ADDR_FEAT_CTRL    3'h5
`define ADDR_ENH_FEAT     3'h6
`define ADDR_PROG_TRIG    3'h7
`define ADDR_STATUS       3'h0
`define LCR_RESET         8'h00
`define MCR_RESET         8'h00
`define EFR_ENH_BIT       4
`define FEATURE_CONTROL_REG_DIR_BIT      7
`define LCR_DIV_BIT       7
`define LCR_BRK_BIT       6
`define LCR_FORCE_BIT     5
`define LCR_EVEN_BIT      4
`define LCR_PAR_BIT       3
`define LCR_STOP_BIT      2
`define MCR_DTR_BIT       0
`define MCR_RTS_BIT       1
`define MCR_OP1_BIT       2
`define MCR_OP2_BIT       3
`define MCR_LOOP_BIT      4
`define MCR_XANY_BIT      5
`define MCR_IR_BIT        6
`define TRIG_RESET        8'h01
`endif

/* hdl/uart_fmt_pkg.sv */
// Types shared by the format and trigger control design.
// Assumes the defs header sits beside it.
package uart_fmt_pkg;
  typedef enum logic [1:0] {
    TABLE_A = 2'b00,
    TABLE_B = 2'b01,
    TABLE_C = 2'b10,
    TABLE_D = 2'b11
  } trig_table_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_ARM  = 2'b01,
    TX_LOW  = 2'b10
  } tx_irq_state_t;
endpackage

/* hdl/trig_lut.sv */
// Trigger level lookup for tables A to C, and the programmable table D.
// Assumes select codes and table come from registers on the same clock.
`timescale 1ns/1ps
`include "uart_fmt_defs.svh"
module trig_lut
  import uart_fmt_pkg::*;
(
  input  wire uart_fmt_pkg::trig_table_t tbl_in,
  input  wire logic [1:0]                rx_sel_in,
  input  wire logic [1:0]                tx_sel_in,
  input  wire logic [7:0]                prog_rx_in,
  input  wire logic [7:0]                prog_tx_in,
  output logic      [7:0]                rx_level_out,
  output logic      [7:0]                tx_level_out
);
  always_comb begin
    rx_level_out = 8'h01;
    tx_level_out = 8'h01;
    case (tbl_in)
      TABLE_A: begin
        case (rx_sel_in)
          2'b00:   rx_level_out = 8'h01;
          2'b01:   rx_level_out = 8'h04;
          2'b10:   rx_level_out = 8'h08;
          default: rx_level_out = 8'h0e;
        endcase
        tx_level_out = 8'h01;
      end
      TABLE_B: begin
        case (rx_sel_in)
          2'b00:   rx_level_out = 8'h08;
          2'b01:   rx_level_out = 8'h10;
          2'b10:   rx_level_out = 8'h18;
          default: rx_level_out = 8'h1c;
        endcase
        case (tx_sel_in)
          2'b00:   tx_level_out = 8'h10;
          2'b01:   tx_level_out = 8'h08;
          2'b10:   tx_level_out = 8'h18;
          default: tx_level_out = 8'h1e;
        endcase
      end
      TABLE_C: begin
        case (rx_sel_in)
          2'b00:   rx_level_out = 8'h08;
          2'b01:   rx_level_out = 8'h10;
          2'b10:   rx_level_out = 8'h38;
          default: rx_level_out = 8'h3c;
        endcase
        case (tx_sel_in)
          2'b00:   tx_level_out = 8'h08;
          2'b01:   tx_level_out = 8'h10;
          2'b10:   tx_level_out = 8'h20;
          default: tx_level_out = 8'h38;
        endcase
      end
      TABLE_D: begin
        rx_level_out = prog_rx_in;
        tx_level_out = prog_tx_in;
      end
      default: begin
        rx_level_out = 8'h01;
        tx_level_out = 8'h01;
      end
    endcase
  end
endmodule

/* hdl/uart_format_trigger_modem_ctrl.sv */
// Configuration, trigger and modem control for one UART channel.
// Assumes FIFO counts, flow state and serial datapath on clk_in.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
`include "uart_fmt_defs.svh"
module uart_format_trigger_modem_ctrl
  import uart_fmt_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic [2:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic [7:0] rx_count_in,
  input  wire logic [7:0] tx_count_in,
  input  wire logic       tx_reload_in,
  input  wire logic       rx_char_in,
  input  wire logic       rx_is_xonxoff_in,
  input  wire logic       sw_flow_in,
  input  wire logic       ring_indicator_in,
  input  wire logic       core_irq_in,
  output logic            tx_irq_out,
  output logic            rx_irq_out,
  output logic [1:0]      rx_trig_sel_out,
  output logic [7:0]      rx_level_out,
  output logic [7:0]      tx_level_out,
  output logic            dma_mode_out,
  output logic [3:0]      word_bits_out,
  output logic            stop_half_out,
  output logic [1:0]      stop_bits_out,
  output logic            parity_en_out,
  output logic            parity_even_out,
  output logic            parity_forced_out,
  output logic            parity_force_val_out,
  output logic            break_out,
  output logic            divisor_sel_out,
  output logic            divisor_wr_out,
  output logic            divisor_high_byte_out,
  output logic            dtr_n_out,
  output logic            rts_n_out,
  output logic            rts_auto_ok_out,
  output logic            general_output_two_out,
  output logic            irq_out,
  output logic            irq_oe_out,
  output logic            loopback_out,
  output logic            ring_status_out,
  output logic            xon_any_out,
  output logic            resume_tx_out,
  output logic            rx_store_out,
  output logic            irda_en_out,
  output logic            irda_idle_low_out
);
  logic [7:0] line_control_q;
  logic [7:0] modem_control_q;
  logic [7:0] enhanced_feature_reg_q;
  logic [7:0] feature_control_reg_q;
  logic [7:0] prog_rx_q;
  logic [7:0] prog_tx_q;
  logic [7:0] divisor_low_q;
  logic [7:0] divisor_high_q;
  logic       dma_q;
  logic [1:0] rx_sel_q;
  logic [1:0] tx_sel_q;
  logic [7:0] rdata_q;
  logic       ri_meta_q;
  logic       ri_sync_q;
  logic [7:0] rx_count_prev_q;
  logic [7:0] tx_count_prev_q;
  logic       tx_irq_q;
  logic       rx_irq_q;
  logic       filled_above_q;
  logic       fifo_wr;
  logic       lcr_wr;
  logic       enh_en;
  logic       ri_level;
  trig_table_t tbl;

  function automatic logic wr_hit(input logic [2:0] a, input logic [2:0] t);
    wr_hit = (a == t);
  endfunction

  assign fifo_wr = wr_in && wr_hit(addr_in, `ADDR_FIFO_CTRL);
  assign lcr_wr  = wr_in && wr_hit(addr_in, `ADDR_LINE_CTRL);
  assign enh_en  = enhanced_feature_reg_q[`EFR_ENH_BIT];
  assign tbl     = trig_table_t'(feature_control_reg_q[5:4]);

  // FIFO control reads back IRQ status and RX select; fields are held for the datapath
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dma_q    <= 1'b0;
      rx_sel_q <= 2'b00;
      tx_sel_q <= 2'b00;
    end else if (fifo_wr && wdata_in[0]) begin
      dma_q    <= wdata_in[3];
      rx_sel_q <= wdata_in[7:6];
      if (enh_en) begin
        tx_sel_q <= wdata_in[5:4];
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      line_control_q <= `LCR_RESET;
    end else if (lcr_wr) begin
      line_control_q <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      modem_control_q <= `MCR_RESET;
    end else if (wr_in && wr_hit(addr_in, `ADDR_MODEM_CTRL)) begin
      modem_control_q <= wdata_in;
    end
  end

  // Table select is one field, so the last write wins for both sides
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      feature_control_reg_q  <= 8'h00;
      enhanced_feature_reg_q <= 8'h00;
    end else if (wr_in) begin
      if (wr_hit(addr_in, `ADDR_FEAT_CTRL)) begin
        feature_control_reg_q <= wdata_in;
      end
      if (wr_hit(addr_in, `ADDR_ENH_FEAT)) begin
        enhanced_feature_reg_q <= wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prog_rx_q <= `TRIG_RESET;
      prog_tx_q <= `TRIG_RESET;
    end else if (wr_in && wr_hit(addr_in, `ADDR_PROG_TRIG)) begin
      if (feature_control_reg_q[`FEATURE_CONTROL_REG_DIR_BIT]) begin
        prog_tx_q <= wdata_in;
      end else begin
        prog_rx_q <= wdata_in;
      end
    end
  end

  // Divisor latch shares the data addresses while the access bit is set
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      divisor_low_q  <= 8'h00;
      divisor_high_q <= 8'h00;
    end else if (wr_in && line_control_q[`LCR_DIV_BIT]) begin
      if (wr_hit(addr_in, `ADDR_DATA0)) begin
        divisor_low_q <= wdata_in;
      end
      if (wr_hit(addr_in, `ADDR_DATA1)) begin
        divisor_high_q <= wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_q <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        `ADDR_DATA0: rdata_q <= line_control_q[`LCR_DIV_BIT] ?
                                divisor_low_q : 8'h00;
        `ADDR_DATA1: rdata_q <= line_control_q[`LCR_DIV_BIT] ?
                                divisor_high_q : 8'h00;
        `ADDR_FIFO_CTRL:  rdata_q <= {tx_irq_q, rx_irq_q, 4'h0,
                                      rx_sel_q};
        `ADDR_LINE_CTRL:  rdata_q <= line_control_q;
        `ADDR_MODEM_CTRL: rdata_q <= modem_control_q;
        `ADDR_FEAT_CTRL:  rdata_q <= feature_control_reg_q;
        `ADDR_ENH_FEAT:   rdata_q <= enhanced_feature_reg_q;
        `ADDR_PROG_TRIG:  rdata_q <= feature_control_reg_q[7] ?
                                     prog_tx_q : prog_rx_q;
        default:          rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign rdata_out = rdata_q;

  trig_lut u_trig_lut (
    .tbl_in       (tbl),
    .rx_sel_in    (rx_sel_q),
    .tx_sel_in    (tx_sel_q),
    .prog_rx_in   (prog_rx_q),
    .prog_tx_in   (prog_tx_q),
    .rx_level_out (rx_level_out),
    .tx_level_out (tx_level_out)
  );

  // Remember whether the TX count has gone above the TX trigger since the last reload
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      filled_above_q <= 1'b0;
    end else if (tx_reload_in) begin
      filled_above_q <= (tx_count_in > tx_level_out);
    end else if (tx_count_in > tx_level_out) begin
      filled_above_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_count_prev_q <= 8'h00;
      rx_count_prev_q <= 8'h00;
    end else begin
      tx_count_prev_q <= tx_count_in;
      rx_count_prev_q <= rx_count_in;
    end
  end

  // Level outputs; the interrupt core clears by draining or refilling
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_irq_q <= 1'b0;
    end else if (filled_above_q) begin
      tx_irq_q <= (tx_count_in < tx_level_out);
    end else begin
      tx_irq_q <= (tx_count_in == 8'h00);
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_irq_q <= 1'b0;
    end else begin
      rx_irq_q <= (rx_count_in >= rx_level_out);
    end
  end
  assign tx_irq_out = tx_irq_q;
  assign rx_irq_out = rx_irq_q;

  // Ring pin is asynchronous; only the second stage is read
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ri_meta_q <= 1'b1;
      ri_sync_q <= 1'b1;
    end else begin
      ri_meta_q <= ring_indicator_in;
      ri_sync_q <= ri_meta_q;
    end
  end

  assign ri_level = modem_control_q[`MCR_LOOP_BIT] ?
                    modem_control_q[`MCR_OP1_BIT] : !ri_sync_q;
  assign ring_status_out = ri_level;

  assign rx_trig_sel_out      = rx_sel_q;
  assign dma_mode_out         = dma_q;
  assign word_bits_out        = 4'h5 +
                                {2'b00, line_control_q[1:0]};
  assign stop_half_out        = line_control_q[`LCR_STOP_BIT] &&
                                (line_control_q[1:0] == 2'b00);
  assign stop_bits_out        = line_control_q[`LCR_STOP_BIT] ?
                                2'h2 : 2'h1;
  assign parity_en_out        = line_control_q[`LCR_PAR_BIT];
  assign parity_even_out      = line_control_q[`LCR_EVEN_BIT];
  assign parity_forced_out    = line_control_q[`LCR_PAR_BIT] &&
                                line_control_q[`LCR_FORCE_BIT];
  assign parity_force_val_out = !line_control_q[`LCR_EVEN_BIT];
  assign break_out            = line_control_q[`LCR_BRK_BIT];
  assign divisor_sel_out      = line_control_q[`LCR_DIV_BIT];
  assign divisor_wr_out       = wr_in && line_control_q[`LCR_DIV_BIT] &&
                                wr_hit(addr_in, `ADDR_DATA1);
  assign divisor_high_byte_out = divisor_high_q[0];

  // DTR and RTS outputs are held high in loopback so the far end sees idle
  assign dtr_n_out = modem_control_q[`MCR_LOOP_BIT] ||
                     !modem_control_q[`MCR_DTR_BIT];
  assign rts_n_out = modem_control_q[`MCR_LOOP_BIT] ||
                     !modem_control_q[`MCR_RTS_BIT];
  assign rts_auto_ok_out = modem_control_q[`MCR_RTS_BIT];
  assign general_output_two_out = !modem_control_q[`MCR_OP2_BIT];
  assign irq_oe_out   = modem_control_q[`MCR_OP2_BIT];
  assign irq_out      = core_irq_in && modem_control_q[`MCR_OP2_BIT];
  assign loopback_out = modem_control_q[`MCR_LOOP_BIT];
  assign xon_any_out  = modem_control_q[`MCR_XANY_BIT];
  assign resume_tx_out = rx_char_in &&
                         modem_control_q[`MCR_XANY_BIT];
  assign rx_store_out  = rx_char_in &&
                         !(sw_flow_in && rx_is_xonxoff_in);
  assign irda_en_out       = modem_control_q[`MCR_IR_BIT];
  assign irda_idle_low_out = modem_control_q[`MCR_IR_BIT];

  default clocking cb_assert @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_fifo_write_ok;
    fifo_wr && wdata_in[0];
  endsequence
  sequence s_mcr_write;
    wr_in && wr_hit(addr_in, `ADDR_MODEM_CTRL);
  endsequence

  AST_DMA_FOLLOWS: assert property (
    s_fifo_write_ok |=> dma_mode_out == $past(wdata_in[3]))
    else $error("dma mode not taken");
  AST_TX_LOCKED: assert property (
    (s_fifo_write_ok and !enh_en) |=> $stable(tx_sel_q))
    else $error("tx trigger written while locked");
  AST_TABLE_A_TX: assert property (
    tbl == TABLE_A |-> tx_level_out == 8'h01)
    else $error("table A tx level wrong");
  AST_TABLE_C_RX: assert property (
    (tbl == TABLE_C && rx_sel_q == 2'b11) |-> rx_level_out == 8'h3c)
    else $error("table C rx level wrong");
  AST_RX_IRQ: assert property (
    rx_count_in >= rx_level_out && $stable(rx_level_out) |=> rx_irq_out)
    else $error("rx irq missing");
  AST_TX_EMPTY: assert property (
    tx_count_in == 8'h00 |=> tx_irq_out)
    else $error("tx irq missing on empty");
  AST_BREAK: assert property (
    lcr_wr && wdata_in[`LCR_BRK_BIT] |=> break_out [*2] or
      (break_out ##1 lcr_wr))
    else $error("break not held");
  AST_STOP: assert property (
    lcr_wr && wdata_in[`LCR_STOP_BIT] && wdata_in[1:0] == 2'b00
      |=> stop_half_out && stop_bits_out == 2'h2 && word_bits_out == 4'h5)
    else $error("stop length wrong");
  AST_OP2: assert property (
    s_mcr_write |=> general_output_two_out == !$past(wdata_in[3]) &&
      irq_oe_out == $past(wdata_in[3]))
    else $error("op2 and irq enable disagree");
  AST_RING_LOOP: assert property (
    (s_mcr_write and wdata_in[`MCR_LOOP_BIT])
      |=> ring_status_out == $past(wdata_in[`MCR_OP1_BIT]))
    else $error("loopback ring wrong");
endmodule

/* testbench/remote_line_model.sv */
// Far side of the channel: modem ring pin and received-character events.
// Assumes the block's clock; requests come from the bench.
`timescale 1ns/1ps
module remote_line_model (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       ring_req_in,
  input  wire logic       char_req_in,
  input  wire logic       xon_req_in,
  input  wire logic [3:0] delay_in,
  output logic            ring_indicator_n_out,
  output logic            rx_char_out,
  output logic            rx_is_xonxoff_out
);
  logic [4:0] wait_q;
  logic       kind_q;
  // Ring pin is active low and idles high
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ring_indicator_n_out <= 1'b1;
    end else begin
      ring_indicator_n_out <= !ring_req_in;
    end
  end
  // One-cycle character event, after a chosen delay
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wait_q            <= 5'h00;
      kind_q            <= 1'b0;
      rx_char_out       <= 1'b0;
      rx_is_xonxoff_out <= 1'b0;
    end else begin
      rx_char_out <= 1'b0;
      // Kind flag only meaningful with the event; toggles otherwise
      rx_is_xonxoff_out <= !rx_is_xonxoff_out;
      if (char_req_in) begin
        wait_q <= {1'b1, delay_in};
        kind_q <= xon_req_in;
      end else if (wait_q[4] && wait_q[3:0] == 4'h0) begin
        wait_q            <= 5'h00;
        rx_char_out       <= 1'b1;
        rx_is_xonxoff_out <= kind_q;
      end else if (wait_q[4]) begin
        wait_q <= wait_q - 5'h01;
      end
    end
  end
endmodule

/* testbench/tb_uart_format_trigger_modem_ctrl.sv */
// Self-checking bench for the format, trigger and modem control block.
// Assumes the design package and defs header are compiled first.
`timescale 1ns/1ps
`include "uart_fmt_defs.svh"
module tb_uart_format_trigger_modem_ctrl;
  import uart_fmt_pkg::*;
  logic       clk_in = 1'b0, reset_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00, rx_count_in = 8'h00, tx_count_in = 8'h00;
  logic       tx_reload_in = 1'b0, sw_flow_in = 1'b0, core_irq_in = 1'b0;
  logic       ring_req = 1'b0, char_req = 1'b0, xon_req = 1'b0;
  logic [3:0] delay = 4'h0;
  logic       ring_indicator_in, rx_char_in, rx_is_xonxoff_in;
  logic [7:0] rdata_out, rx_level_out, tx_level_out;
  logic [3:0] word_bits_out;
  logic [1:0] rx_trig_sel_out, stop_bits_out;
  logic       tx_irq_out, rx_irq_out, dma_mode_out, stop_half_out;
  logic       parity_en_out, parity_even_out, parity_forced_out;
  logic       parity_force_val_out, break_out, divisor_sel_out;
  logic       divisor_wr_out, divisor_high_byte_out, dtr_n_out, rts_n_out;
  logic       rts_auto_ok_out, general_output_two_out, irq_out, irq_oe_out;
  logic       loopback_out, ring_status_out, xon_any_out, resume_tx_out;
  logic       rx_store_out, irda_en_out, irda_idle_low_out;
  logic [7:0] lcr_m = 8'h00, mcr_m = 8'h00, feature_control_reg_m = 8'h00, enh_m = 8'h00;
  logic [7:0] prx_m = 8'h01, ptx_m = 8'h01, rnd = 8'h41;
  logic [1:0] rxs = 2'b00, txs = 2'b00;
  logic       dma_m = 1'b0, div_seen, res_seen, sto_seen, filled;
  int         n_errors = 0, samples_checked = 0, cycles = 0;
  int rx_tab[3][4] = '{'{1, 4, 8, 14}, '{8, 16, 24, 28}, '{8, 16, 56, 60}};
  int tx_tab[3][4] = '{'{1, 1, 1, 1}, '{16, 8, 24, 30}, '{8, 16, 32, 56}};

  uart_format_trigger_modem_ctrl i_uart_format_trigger_modem_ctrl (
    .clk_in, .reset_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .rx_count_in, .tx_count_in, .tx_reload_in, .rx_char_in,
    .rx_is_xonxoff_in, .sw_flow_in, .ring_indicator_in, .core_irq_in,
    .tx_irq_out, .rx_irq_out, .rx_trig_sel_out, .rx_level_out,
    .tx_level_out, .dma_mode_out, .word_bits_out, .stop_half_out,
    .stop_bits_out, .parity_en_out, .parity_even_out, .parity_forced_out,
    .parity_force_val_out, .break_out, .divisor_sel_out, .divisor_wr_out,
    .divisor_high_byte_out, .dtr_n_out, .rts_n_out, .rts_auto_ok_out,
    .general_output_two_out, .irq_out, .irq_oe_out, .loopback_out,
    .ring_status_out, .xon_any_out, .resume_tx_out, .rx_store_out,
    .irda_en_out, .irda_idle_low_out);
  remote_line_model i_remote_line_model (
    .clk_in, .reset_n_in, .ring_req_in(ring_req), .char_req_in(char_req),
    .xon_req_in(xon_req), .delay_in(delay),
    .ring_indicator_n_out(ring_indicator_in), .rx_char_out(rx_char_in),
    .rx_is_xonxoff_out(rx_is_xonxoff_in));

  always #10 clk_in = ~clk_in;
  always @(negedge clk_in) begin
    if (resume_tx_out === 1'b1) res_seen = 1'b1;
    if (rx_store_out === 1'b1) sto_seen = 1'b1;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles > 20000) begin
      n_errors++;
      stop_test();
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [7:0] exp_rx();
    return (feature_control_reg_m[5:4] == 2'b11) ? prx_m : 8'(rx_tab[feature_control_reg_m[5:4]][rxs]);
  endfunction
  function automatic logic [7:0] exp_tx();
    return (feature_control_reg_m[5:4] == 2'b11) ? ptx_m : 8'(tx_tab[feature_control_reg_m[5:4]][txs]);
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(negedge clk_in);
    div_seen = divisor_wr_out;
    @(posedge clk_in);
    wr_in <= 1'b0;
    case (a)
      `ADDR_FIFO_CTRL: if (d[0]) begin
        dma_m = d[3];
        rxs = d[7:6];
        if (enh_m[`EFR_ENH_BIT]) txs = d[5:4];
      end
      `ADDR_LINE_CTRL: lcr_m = d;
      `ADDR_MODEM_CTRL: mcr_m = d;
      `ADDR_FEAT_CTRL: feature_control_reg_m = d;
      `ADDR_ENH_FEAT: enh_m = d;
      `ADDR_PROG_TRIG: if (feature_control_reg_m[7]) ptx_m = d; else prx_m = d;
      default: ;
    endcase
    @(negedge clk_in);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e, string nm);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    chk(nm, e, rdata_out);
  endtask
  task automatic check_cfg();
    chk("rx_level", exp_rx(), rx_level_out);
    chk("tx_level", exp_tx(), tx_level_out);
    chk("rx_sel", rxs, rx_trig_sel_out);
    chk("dma_mode", dma_m, dma_mode_out);
    chk("word_bits", 5 + lcr_m[1:0], word_bits_out);
    chk("stop_half", lcr_m[2] && !lcr_m[1:0], stop_half_out);
    if (!(lcr_m[2] && !lcr_m[1:0]))
      chk("stop_bits", lcr_m[2] ? 2 : 1, stop_bits_out);
    chk("parity_en", lcr_m[3], parity_en_out);
    if (lcr_m[3] && !lcr_m[5])
      chk("even", lcr_m[4], parity_even_out);
    chk("forced", lcr_m[3] && lcr_m[5], parity_forced_out);
    if (lcr_m[3] && lcr_m[5])
      chk("force_val", !lcr_m[4], parity_force_val_out);
    chk("break", lcr_m[6], break_out);
    chk("div_sel", lcr_m[7], divisor_sel_out);
    chk("dtr_n", mcr_m[4] | !mcr_m[0], dtr_n_out);
    chk("rts_n", mcr_m[4] | !mcr_m[1], rts_n_out);
    chk("rts_auto", mcr_m[1], rts_auto_ok_out);
    chk("gp_two", !mcr_m[3], general_output_two_out);
    chk("irq_oe", mcr_m[3], irq_oe_out);
    chk("irq", mcr_m[3] & core_irq_in, irq_out);
    chk("loopback", mcr_m[4], loopback_out);
    if (mcr_m[4]) chk("ring", mcr_m[2], ring_status_out);
    else chk("ring_pin", ring_req, ring_status_out);
    chk("xon_any", mcr_m[5], xon_any_out);
    chk("irda", mcr_m[6], irda_en_out);
    chk("irda_idle", mcr_m[6], irda_idle_low_out);
  endtask
  task automatic tx_step(input logic rl, input logic [7:0] c);
    @(posedge clk_in);
    tx_reload_in <= rl;
    tx_count_in <= c;
    if (rl) filled = c > exp_tx();
    @(posedge clk_in);
    tx_reload_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    chk("tx_irq", filled ? c < exp_tx() : c == 0, tx_irq_out);
  endtask
  task automatic send(input logic x, input logic [3:0] d, input logic es);
    res_seen = 1'b0;
    sto_seen = 1'b0;
    @(posedge clk_in);
    char_req <= 1'b1;
    xon_req <= x;
    delay <= d;
    @(posedge clk_in);
    char_req <= 1'b0;
    repeat (d + 6) @(posedge clk_in);
    @(negedge clk_in);
    chk("resume", mcr_m[5], res_seen);
    chk("store", es, sto_seen);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(negedge clk_in);
    check_cfg();
    rd(`ADDR_LINE_CTRL, `LCR_RESET, "lcr_reset");
    rd(`ADDR_MODEM_CTRL, `MCR_RESET, "mcr_reset");
    $display("test reset done");
    wr(`ADDR_ENH_FEAT, 8'h10);
    for (int t = 0; t < 3; t++) begin
      for (int s = 0; s < 4; s++) begin
        wr(`ADDR_FEAT_CTRL, {2'b00, 2'(t), 4'h0});
        wr(`ADDR_FIFO_CTRL, {2'(s), 2'(3 - s), 1'(s), 3'b001});
        check_cfg();
      end
    end
    wr(`ADDR_ENH_FEAT, 8'h00);
    wr(`ADDR_FIFO_CTRL, 8'h31);
    wr(`ADDR_FIFO_CTRL, 8'hC8);
    check_cfg();
    wr(`ADDR_FEAT_CTRL, 8'h30);
    wr(`ADDR_PROG_TRIG, 8'h20);
    wr(`ADDR_FEAT_CTRL, 8'hB0);
    wr(`ADDR_PROG_TRIG, 8'h28);
    check_cfg();
    rd(`ADDR_PROG_TRIG, 8'h28, "prog_tx");
    $display("test triggers done");
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      wr(`ADDR_LINE_CTRL, rnd);
      check_cfg();
      rd(`ADDR_LINE_CTRL, rnd, "lcr");
    end
    wr(`ADDR_LINE_CTRL, 8'h80);
    wr(`ADDR_DATA1, 8'h5B);
    chk("div_wr", 1, div_seen);
    chk("div_high", 1, divisor_high_byte_out);
    rd(`ADDR_DATA1, 8'h5B, "div_high_rd");
    wr(`ADDR_LINE_CTRL, 8'h00);
    wr(`ADDR_DATA1, 8'hA4);
    chk("div_wr_off", 0, div_seen);
    rd(`ADDR_DATA1, 8'h00, "data1_rd");
    $display("test line done");
    @(posedge clk_in);
    ring_req <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      @(posedge clk_in);
      core_irq_in <= rnd[7];
      wr(`ADDR_MODEM_CTRL, rnd & 8'h7F);
      check_cfg();
      rd(`ADDR_MODEM_CTRL, rnd & 8'h7F, "mcr");
    end
    $display("test modem done");
    wr(`ADDR_FEAT_CTRL, 8'h00);
    wr(`ADDR_FIFO_CTRL, 8'h81);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_in);
      rx_count_in <= 8'(7 + k * 3) & 8'h0F;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      chk("rx_irq", rx_count_in >= exp_rx(), rx_irq_out);
    end
    wr(`ADDR_ENH_FEAT, 8'h10);
    wr(`ADDR_FEAT_CTRL, 8'h10);
    wr(`ADDR_FIFO_CTRL, 8'h11);
    tx_step(1'b1, 8'h14);
    tx_step(1'b0, 8'h07);
    tx_step(1'b0, 8'h08);
    tx_step(1'b1, 8'h05);
    tx_step(1'b0, 8'h05);
    tx_step(1'b0, 8'h00);
    $display("test irq done");
    wr(`ADDR_MODEM_CTRL, 8'h20);
    @(posedge clk_in);
    sw_flow_in <= 1'b1;
    send(1'b0, 4'h0, 1'b1);
    send(1'b1, 4'h3, 1'b0);
    @(posedge clk_in);
    sw_flow_in <= 1'b0;
    send(1'b1, 4'h9, 1'b1);
    wr(`ADDR_MODEM_CTRL, 8'h00);
    send(1'b0, 4'h2, 1'b1);
    $display("test xon_any done");
    stop_test();
  end
endmodule
